// [bench/mrl_ctrl_model.sv]
// Purpose: Controller model issuing mode-register commands
// Assumes: Commands change just after the falling edge
// Notes:   Idle bus shows the inverse of the last address and operand
`timescale 1ns/1ps
module mrl_ctrl_model
  import mrl_pkg::*;
(
  input  wire logic clk,
  output mrl_cmd_s  cmd
);
  initial cmd = '0;

  // One-cycle write or read, then release with scrambled lines
  task automatic issue(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
    @(negedge clk);
    cmd = '{wr: w, rd: !w, addr: a, op: d};
    @(negedge clk);
    cmd = '{wr: 1'b0, rd: 1'b0, addr: ~a, op: ~d};
    // Registered config settles one cycle after a write
    if (w) begin
      @(negedge clk);
    end
  endtask : issue
endmodule : mrl_ctrl_model

// [bench/mrl_mode_regs_properties.sv]
// Purpose: Port-level checks for the mode-register bank
// Assumes: Precharge delays do not change while a timer runs
// Notes:   Bound to every mrl_mode_regs instance below
`timescale 1ns/1ps
module mrl_mode_regs_chk
  import mrl_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire mrl_cmd_s   MR_CMD,
  input wire logic       WR_AP_DONE,
  input wire logic       RD_AP_DONE,
  input wire logic       RD_BL32,
  input wire mrl_cfg_s   CFG,
  input wire logic       MR_RVALID,
  input wire logic       REPAIR_MODE,
  input wire logic       REPAIR_LOCK,
  input wire logic       SELFREFRESH_ABORT,
  input wire logic [1:0] THERMAL_OFFSET,
  input wire logic       WR_PRECHARGE,
  input wire logic       RD_PRECHARGE
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic       wr3, wr4, rd4;
  logic [6:0] wc_q, rc_q, rdel_q;
  assign wr3 = MR_CMD.wr && MR_CMD.addr == MRL_ADDR_DRIVE;
  assign wr4 = MR_CMD.wr && MR_CMD.addr == MRL_ADDR_THERM;
  assign rd4 = MR_CMD.rd && MR_CMD.addr == MRL_ADDR_THERM;

  // Cycles since an accepted precharge start, zero while idle
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wc_q   <= 7'h0;
      rc_q   <= 7'h0;
      rdel_q <= 7'h0;
    end else begin
      if (WR_PRECHARGE) wc_q <= 7'h0;
      else if (wc_q != 7'h0) wc_q <= wc_q + 7'h1;
      else if (WR_AP_DONE) wc_q <= 7'h1;
      if (RD_PRECHARGE) rc_q <= 7'h0;
      else if (rc_q != 7'h0) rc_q <= rc_q + 7'h1;
      else if (RD_AP_DONE) begin
        rc_q   <= 7'h1;
        rdel_q <= {1'b0, CFG.read_to_pre} + (RD_BL32 ? 7'h8 : 7'h0);
      end
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  property p_wr_fire;
    wc_q != 7'h0 && wc_q == {1'b0, CFG.write_recovery} |-> WR_PRECHARGE;
  endproperty
  a_wr_fire: assert property (p_wr_fire)
    else $error("write precharge missing at recovery count");
  property p_wr_early; WR_PRECHARGE |-> wc_q == {1'b0, CFG.write_recovery};
  endproperty
  a_wr_early: assert property (p_wr_early)
    else $error("write precharge at wrong count");
  property p_rd_fire; rc_q != 7'h0 && rc_q == rdel_q |-> RD_PRECHARGE;
  endproperty
  a_rd_fire: assert property (p_rd_fire)
    else $error("read precharge missing at its count");
  property p_rvalid; rd4 |=> MR_RVALID; endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("no read answer for thermal status");
  property p_rv_only; MR_RVALID |-> $past(rd4); endproperty
  a_rv_only: assert property (p_rv_only)
    else $error("read answer without thermal status read");
  property p_lock_set; wr3 && MR_CMD.op[MRL_B_LOCK] |=> REPAIR_LOCK;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("repair lock not set");
  property p_lock_hold; $past(REPAIR_LOCK) |-> REPAIR_LOCK; endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("repair lock cleared without reset");
  property p_repe_block; REPAIR_LOCK && wr4 && !REPAIR_MODE |=> !REPAIR_MODE;
  endproperty
  a_repe_block: assert property (p_repe_block)
    else $error("repair entry taken while locked");
  property p_repe_set;
    !REPAIR_LOCK && wr4 |=> REPAIR_MODE == $past(MR_CMD.op[MRL_B_REPE]);
  endproperty
  a_repe_set: assert property (p_repe_set)
    else $error("repair entry not following write");
  property p_abort;
    wr4 |=> SELFREFRESH_ABORT == $past(MR_CMD.op[MRL_B_SRAB]);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort bit not stored");
  property p_offset; wr4 && MR_CMD.op[6:5] != MRL_TOF_RSV
    |=> THERMAL_OFFSET == $past(MR_CMD.op[6:5]); endproperty
  a_offset: assert property (p_offset)
    else $error("thermal offset not stored");
  property p_rl_col; CFG.read_inversion_enable |-> CFG.read_latency
    inside {6'd6, 6'd12, 6'd16, 6'd22, 6'd28, 6'd32, 6'd36, 6'd40};
  endproperty
  a_rl_col: assert property (p_rl_col)
    else $error("read latency outside inversion column");

  c_bl32: cover property (RD_AP_DONE && RD_BL32);
  c_refuse: cover property (REPAIR_LOCK && wr4 && MR_CMD.op[MRL_B_REPE]);
  c_read: cover property (MR_RVALID);
endmodule : mrl_mode_regs_chk

bind mrl_mode_regs mrl_mode_regs_chk u_chk (
  .REF_CLK, .NRST, .MR_CMD, .WR_AP_DONE, .RD_AP_DONE, .RD_BL32, .CFG,
  .MR_RVALID, .REPAIR_MODE, .REPAIR_LOCK, .SELFREFRESH_ABORT,
  .THERMAL_OFFSET, .WR_PRECHARGE, .RD_PRECHARGE
);

// [bench/mrl_mode_regs_tb_top.sv]
// Purpose: Self-checking bench for the mode-register bank
// Assumes: Controller model drives all commands
// Notes:   Table rows cover every latency code
`timescale 1ns/1ps
module mrl_mode_regs_tb_top
  import mrl_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  typedef struct packed {
    logic [7:0] lat;
    logic [7:0] drv;
    logic [5:0] rl, wl, write_recovery_cycles, read_to_precharge_cycles;
  } mrl_row_s;
  localparam mrl_row_s ROWS [8] = '{
    '{8'h00, 8'h31, 6'd6, 6'd4, 6'd6, 6'd8},
    '{8'h49, 8'h4a, 6'd12, 6'd8, 6'd10, 6'd8},
    '{8'h12, 8'h90, 6'd14, 6'd8, 6'd16, 6'd8},
    '{8'h5b, 8'h59, 6'd22, 6'd18, 6'd20, 6'd8},
    '{8'ha4, 8'h20, 6'd24, 6'd12, 6'd24, 6'd10},
    '{8'h6d, 8'h68, 6'd32, 6'd26, 6'd30, 6'd12},
    '{8'h76, 8'h30, 6'd32, 6'd30, 6'd34, 6'd14},
    '{8'h3f, 8'h70, 6'd40, 6'd18, 6'd40, 6'd16}};
  logic       clk, nrst, tderate, wr_ap, rd_ap, bl32, rvalid;
  logic       rmode, rlock, abort, wr_pre, rd_pre;
  logic [2:0] trate;
  logic [1:0] tof;
  logic [7:0] rdata;
  mrl_cmd_s   cmd;
  mrl_cfg_s   cfg;
  int         bad_count, checks_done;

  mrl_ctrl_model u_ctrl (.clk(clk), .cmd(cmd));
  mrl_mode_regs u_dut (
    .REF_CLK(clk), .NRST(nrst), .MR_CMD(cmd), .TEMP_RATE(trate),
    .TEMP_DERATE(tderate), .WR_AP_DONE(wr_ap), .RD_AP_DONE(rd_ap),
    .RD_BL32(bl32), .CFG(cfg), .MR_RDATA(rdata), .MR_RVALID(rvalid),
    .REPAIR_MODE(rmode), .REPAIR_LOCK(rlock), .SELFREFRESH_ABORT(abort),
    .THERMAL_OFFSET(tof), .WR_PRECHARGE(wr_pre), .RD_PRECHARGE(rd_pre));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [31:0] exp_cfg(mrl_row_s r);
    return {r.rl, r.wl, r.write_recovery_cycles, r.read_to_precharge_cycles, r.drv[1], r.drv[7], r.drv[6],
            r.drv[0], r.drv[5:3], r.lat[7]};
  endfunction : exp_cfg

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Thermal status read, compared under a mask
  task automatic rd4(input logic [7:0] exp, input logic [7:0] m);
    u_ctrl.issue(1'b0, MRL_ADDR_THERM, 8'h00);
    chk("rvalid", 32'(rvalid), 32'h1);
    chk("rdata", 32'(rdata & m), 32'(exp));
  endtask : rd4

  // Auto-precharge start, counting cycles up to the fire pulse
  task automatic ap(input logic w, input logic b, input int exp);
    int n;
    @(negedge clk);
    wr_ap = w;
    rd_ap = !w;
    bl32  = b;
    @(negedge clk);
    wr_ap = 1'b0;
    rd_ap = 1'b0;
    n = 1;
    while (!(w ? wr_pre : rd_pre) && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("ap delay", 32'(n), 32'(exp));
  endtask : ap

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // ==========================================================================
  // Clock, watchdog and test sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Span far above the cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial begin
    {nrst, tderate, wr_ap, rd_ap, bl32} = 5'h0;
    trate = 3'h3;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk("cfg reset", cfg, exp_cfg(ROWS[0]));
    chk("outs reset", 32'({rlock, rmode, abort, tof}), 32'h0);
    rd4(8'h00, 8'h80);
    for (int i = 0; i < 8; i++) begin
      u_ctrl.issue(1'b1, MRL_ADDR_LAT, ROWS[i].lat);
      u_ctrl.issue(1'b1, MRL_ADDR_DRIVE, ROWS[i].drv);
      chk("cfg row", cfg, exp_cfg(ROWS[i]));
    end
    $display("rows done");
    ap(1'b1, 1'b0, 40);
    ap(1'b0, 1'b0, 16);
    ap(1'b0, 1'b1, 24);
    $display("precharge done");
    u_ctrl.issue(1'b1, MRL_ADDR_DRIVE, 8'h78);
    u_ctrl.issue(1'b1, MRL_ADDR_DRIVE, 8'h40);
    chk("strength", 32'(cfg.pulldown_strength), 32'h6);
    u_ctrl.issue(1'b1, 6'h05, 8'h00);
    chk("unmapped", 32'(cfg.read_latency), 32'd40);
    u_ctrl.issue(1'b0, MRL_ADDR_LAT, 8'h00);
    chk("no answer", 32'(rvalid), 32'h0);
    u_ctrl.issue(1'b1, MRL_ADDR_SETPT, 8'h40);
    u_ctrl.issue(1'b1, MRL_ADDR_LAT, 8'h00);
    chk("sp write", 32'(cfg.read_latency), 32'd40);
    u_ctrl.issue(1'b1, MRL_ADDR_SETPT, 8'hc0);
    chk("sp op1", 32'(cfg.read_latency), 32'd6);
    u_ctrl.issue(1'b1, MRL_ADDR_SETPT, 8'h00);
    chk("sp op0", 32'(cfg.read_latency), 32'd40);
    $display("set point done");
    for (int i = 0; i < 8; i++) begin
      trate = 3'(i + 4);
      repeat (5) @(negedge clk);
      rd4({5'h10, 3'(i + 4)}, 8'h87);
    end
    rd4(8'h00, 8'h80);
    tderate = 1'b1;
    repeat (5) @(negedge clk);
    rd4(8'h86, 8'h87);
    tderate = 1'b0;
    $display("thermal read done");
    u_ctrl.issue(1'b1, MRL_ADDR_THERM, 8'h3f);
    chk("mr4 wr", 32'({tof, rmode, abort}), 32'h7);
    rd4(8'h38, 8'h78);
    u_ctrl.issue(1'b1, MRL_ADDR_THERM, 8'h60);
    chk("rsv offset", 32'({tof, rmode, abort}), 32'h4);
    u_ctrl.issue(1'b1, MRL_ADDR_THERM, 8'h40);
    chk("offset 10", 32'(tof), 32'h2);
    u_ctrl.issue(1'b1, MRL_ADDR_DRIVE, 8'h35);
    u_ctrl.issue(1'b1, MRL_ADDR_DRIVE, 8'h31);
    chk("lock", 32'(rlock), 32'h1);
    u_ctrl.issue(1'b1, MRL_ADDR_THERM, 8'h18);
    chk("locked entry", 32'({rmode, abort}), 32'h1);
    $display("repair done");
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk("lock reset", 32'(rlock), 32'h0);
    chk("cfg reset2", cfg, exp_cfg(ROWS[0]));
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    $display("reset done");
    conclude();
  end
endmodule : mrl_mode_regs_tb_top

// [src/mrl_mode_regs.sv]
// Purpose: Mode-register bank for latency, drive config and thermal status
// Assumes: Decoded mode-register commands arrive on REF_CLK
// Notes:   Temperature sensor code is an asynchronous pin, synchronised here
//          Reserved strength and offset codes keep the value in force
//          Precharge starts are ignored while that timer still runs
//
// What this block does
// R1: Read latency uses inversion column when read inversion bit is set.
// R2: Write latency uses set B when set select bit is one.
// R3: Controller keeps clock rate inside the chosen latency row limits.
// R4: Write with auto-precharge fires precharge after write recovery cycles.
// R5: Read with auto-precharge fires precharge after read-to-precharge cycles.
// R6: Thirty-two beat reads add eight clocks before auto-precharge.
// R7: Controller programs equal pull-up cal point in both channels first.
// R8: Drive bit one selects write postamble half or one and half clocks.
// R9: Repair lock sets on write of one, clears only at reset.
// R10: Locked device ignores writes of one to repair entry.
// R11: Pull-down strength codes one to six, default six, others reserved.
// R12: Writes update only the set point copy chosen by write select.
// R13: Device operates from copy chosen by operate select only.
// R14: Read-only refresh rate field carries eight documented thermal codes.
// R15: Derating needed at high temperature reports rate code 110.
// R16: Update flag sets on rate change, cleared by thermal status read.
// R17: Update flag is zero at power-up.
// R18: Thermal status write stores bits six to three only.
// R19: Thermal offset codes none, five, ten degrees, eleven reserved.
// R20: Repair entry one enters repair mode, zero exits, default exit.
// R21: Read latency code 000 gives six cycles and is the default.
// R22: Address 3 is drive configuration, address 4 thermal status.
`timescale 1ns/1ps
module mrl_mode_regs
  import mrl_pkg::*;
#(
  parameter int PRE_W = 7
) (
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire mrl_cmd_s   MR_CMD,
  input  wire logic [2:0] TEMP_RATE,
  input  wire logic       TEMP_DERATE,
  input  wire logic       WR_AP_DONE,
  input  wire logic       RD_AP_DONE,
  input  wire logic       RD_BL32,
  output mrl_cfg_s        CFG,
  output logic [7:0]      MR_RDATA,
  output logic            MR_RVALID,
  output logic            REPAIR_MODE,
  output logic            REPAIR_LOCK,
  output logic            SELFREFRESH_ABORT,
  output logic [1:0]      THERMAL_OFFSET,
  output logic            WR_PRECHARGE,
  output logic            RD_PRECHARGE
);

  // ==========================================================================
  // Reset release and sensor synchronisers
  // ==========================================================================
  logic       rst_meta_q;
  logic       rst_n;
  logic [3:0] sens_meta_q;
  logic [3:0] sens_q;

  // Release reset through two flops
  // so no flop leaves reset on a different edge
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Sensor inputs come from another domain; both flops reset to the
  // 1x code with no derate, so the update flag sees no false change
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sens_meta_q <= {1'b0, MRL_RATE_1X};
      sens_q      <= {1'b0, MRL_RATE_1X};
    end else begin
      sens_meta_q <= {TEMP_DERATE, TEMP_RATE};
      sens_q      <= sens_meta_q;
    end
  end

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic wr_lat;
  logic wr_drive;
  logic wr_therm;
  logic wr_setpt;
  logic rd_therm;

  // One-cycle strobes, one for each register address
  assign wr_lat   = MR_CMD.wr && (MR_CMD.addr == MRL_ADDR_LAT);
  assign wr_drive = MR_CMD.wr && (MR_CMD.addr == MRL_ADDR_DRIVE); // R22
  assign wr_therm = MR_CMD.wr && (MR_CMD.addr == MRL_ADDR_THERM); // R22
  assign wr_setpt = MR_CMD.wr && (MR_CMD.addr == MRL_ADDR_SETPT);
  assign rd_therm = MR_CMD.rd && (MR_CMD.addr == MRL_ADDR_THERM);

  // ==========================================================================
  // Set point selects
  // ==========================================================================
  logic spwr_q;
  logic spop_q;

  // Write select steers later writes to one copy;
  // operate select picks the copy in force
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      spwr_q <= 1'b0;
      spop_q <= 1'b0;
    end else if (wr_setpt) begin
      spwr_q <= MR_CMD.op[MRL_B_SPWR];
      spop_q <= MR_CMD.op[MRL_B_SPOP];
    end
  end

  // ==========================================================================
  // Dual copies of latency and drive registers
  // ==========================================================================
  logic [7:0] lat_q   [2];
  logic [7:0] drive_q [2];

  // Only the copy picked by the write select takes the write
  // Both copies reset to the defaults
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lat_q[0]   <= MRL_RST_LAT;    // R21
      lat_q[1]   <= MRL_RST_LAT;
      drive_q[0] <= MRL_RST_DRIVE;  // R11
      drive_q[1] <= MRL_RST_DRIVE;
    end else begin
      if (wr_lat) begin
        lat_q[spwr_q] <= MR_CMD.op; // R12
      end
      if (wr_drive) begin
        drive_q[spwr_q] <= MR_CMD.op; // R12
      end
    end
  end

  // ==========================================================================
  // Active configuration decode
  // ==========================================================================
  logic [7:0] lat_act;
  logic [7:0] drv_act;
  logic [2:0] rl_code;
  logic [2:0] wl_code;
  logic [2:0] pds;

  // Live copy and the code fields cut out of it
  assign lat_act = lat_q[spop_q];   // R13
  assign drv_act = drive_q[spop_q]; // R13
  assign rl_code = lat_act[MRL_B_RL_LO +: 3];
  assign wl_code = lat_act[MRL_B_WL_LO +: 3];
  assign pds     = drv_act[MRL_B_PDS_LO +: 3];

  // Configuration outputs registered
  // so downstream timing paths start at a flop
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CFG <= '0;
      CFG.read_latency      <= MRL_RL_NOINV[0];
      CFG.write_latency     <= MRL_WL_A[0];
      CFG.write_recovery    <= MRL_NWR[0];
      CFG.read_to_pre       <= MRL_READ_TO_PRECHARGE_CYCLES[0];
      CFG.pulldown_strength <= MRL_RST_DRIVE[MRL_B_PDS_LO +: 3];
      CFG.pullup_cal_point  <= MRL_RST_DRIVE[MRL_B_PUCAL];
    end else begin
      // write_recovery_cycles follows the write code and read_to_precharge_cycles the read code
      CFG.read_latency <= drv_act[MRL_B_RDINV] ? MRL_RL_INV[rl_code]
                                               : MRL_RL_NOINV[rl_code]; // R1
      CFG.write_latency <= lat_act[MRL_B_WLSET] ? MRL_WL_B[wl_code]
                                                : MRL_WL_A[wl_code];   // R2
      CFG.write_recovery         <= MRL_NWR[wl_code];  // R4
      CFG.read_to_pre            <= MRL_READ_TO_PRECHARGE_CYCLES[rl_code]; // R5
      CFG.write_postamble_len    <= drv_act[MRL_B_WPST]; // R8
      CFG.write_inversion_enable <= drv_act[MRL_B_WRINV];
      CFG.read_inversion_enable  <= drv_act[MRL_B_RDINV];
      CFG.pullup_cal_point       <= drv_act[MRL_B_PUCAL];
      CFG.write_level            <= lat_act[MRL_B_WRLEV];
      // Reserved strength codes leave the previous strength in force
      if (pds != MRL_PDS_RSV0 && pds != MRL_PDS_RSV7) begin
        CFG.pulldown_strength <= pds; // R11
      end
    end
  end

  // ==========================================================================
  // Repair lock and thermal status writable fields
  // ==========================================================================
  logic [1:0] tof_q;

  // Lock is sticky until power-on reset
  // A later write of zero to the lock bit has no effect
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      REPAIR_LOCK <= 1'b0;
    end else if (wr_drive && MR_CMD.op[MRL_B_LOCK]) begin
      REPAIR_LOCK <= 1'b1; // R9
    end
  end

  // Only bits six to three of a thermal status write are kept
  // A refused repair entry still lets the other bits through
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tof_q             <= '0;   // R19
      REPAIR_MODE       <= 1'b0; // R20
      SELFREFRESH_ABORT <= 1'b0;
    end else if (wr_therm) begin
      SELFREFRESH_ABORT <= MR_CMD.op[MRL_B_SRAB]; // R18
      if (MR_CMD.op[MRL_B_TOF_LO +: 2] != MRL_TOF_RSV) begin
        tof_q <= MR_CMD.op[MRL_B_TOF_LO +: 2]; // R19
      end
      if (!(REPAIR_LOCK && MR_CMD.op[MRL_B_REPE])) begin
        REPAIR_MODE <= MR_CMD.op[MRL_B_REPE]; // R10 R20
      end
    end
  end

  assign THERMAL_OFFSET = tof_q;

  // ==========================================================================
  // Refresh rate and update flag
  // ==========================================================================
  logic [2:0] rate_q;
  logic [2:0] rate_d;
  logic       tuf_q;

  // Derate request overrides the sensor code
  assign rate_d = sens_q[3] ? MRL_RATE_DER : sens_q[2:0]; // R14 R15

  // Field starts at the 1x code and then tracks the sensor
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= MRL_RATE_1X;
    end else begin
      rate_q <= rate_d;
    end
  end

  // Change sets the flag and wins over a read in the same cycle
  // so no change is lost between two reads
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tuf_q <= 1'b0; // R17
    end else if (rate_d != rate_q) begin
      tuf_q <= 1'b1; // R16
    end else if (rd_therm) begin
      tuf_q <= 1'b0; // R16
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Valid pulses once per read; data stands until the next read
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MR_RDATA  <= '0;
      MR_RVALID <= 1'b0;
    end else begin
      MR_RVALID <= rd_therm;
      if (rd_therm) begin
        MR_RDATA <= {tuf_q, tof_q, REPAIR_MODE, SELFREFRESH_ABORT, rate_q};
      end
    end
  end

  // ==========================================================================
  // Auto-precharge timers
  // ==========================================================================
  logic [PRE_W-1:0] wr_delay;
  logic [PRE_W-1:0] rd_delay;

  // Delays follow the active config; 32-beat reads add eight
  assign wr_delay = PRE_W'(CFG.write_recovery); // R4
  assign rd_delay = RD_BL32 ? PRE_W'(CFG.read_to_pre + MRL_BL32_ADD)
                            : PRE_W'(CFG.read_to_pre); // R5 R6

  // Write side: starts when a write burst with precharge ends
  mrl_precharge_timer #(.W(PRE_W)) u_wr_pre (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .start (WR_AP_DONE),
    .delay (wr_delay),
    .fire  (WR_PRECHARGE),
    .busy  ()
  );

  // Read side: starts while the timer runs are ignored
  mrl_precharge_timer #(.W(PRE_W)) u_rd_pre (
    .clk   (REF_CLK),
    .rst_n (rst_n),
    .start (RD_AP_DONE),
    .delay (rd_delay),
    .fire  (RD_PRECHARGE),
    .busy  ()
  );

endmodule : mrl_mode_regs

// [src/mrl_pkg.sv]
// Purpose: Shared constants and types for the mode-register latency/thermal block
// Assumes: Eight-bit operands, six-bit register addresses
// Notes:   Latency tables are indexed by the three-bit codes
package mrl_pkg;

  // ==========================================================================
  // Addresses and field positions
  // ==========================================================================
  localparam logic [5:0] MRL_ADDR_LAT   = 6'h02;
  localparam logic [5:0] MRL_ADDR_DRIVE = 6'h03;
  localparam logic [5:0] MRL_ADDR_THERM = 6'h04;
  localparam logic [5:0] MRL_ADDR_SETPT = 6'h0d;

  localparam int MRL_B_PUCAL  = 0;
  localparam int MRL_B_WPST   = 1;
  localparam int MRL_B_LOCK   = 2;
  localparam int MRL_B_PDS_LO = 3;
  localparam int MRL_B_RDINV  = 6;
  localparam int MRL_B_WRINV  = 7;
  localparam int MRL_B_SRAB   = 3;
  localparam int MRL_B_REPE   = 4;
  localparam int MRL_B_TOF_LO = 5;
  localparam int MRL_B_TUF    = 7;
  localparam int MRL_B_RL_LO  = 0;
  localparam int MRL_B_WL_LO  = 3;
  localparam int MRL_B_WLSET  = 6;
  localparam int MRL_B_WRLEV  = 7;
  localparam int MRL_B_SPWR   = 6;
  localparam int MRL_B_SPOP   = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] MRL_RST_DRIVE = 8'h31; // Strength 110, cal point 1
  localparam logic [7:0] MRL_RST_LAT   = 8'h00;
  localparam logic [2:0] MRL_RATE_1X   = 3'h3;
  localparam logic [2:0] MRL_RATE_DER  = 3'h6;
  localparam logic [2:0] MRL_PDS_RSV0  = 3'h0;
  localparam logic [2:0] MRL_PDS_RSV7  = 3'h7;
  localparam logic [1:0] MRL_TOF_RSV   = 2'h3;

  // ==========================================================================
  // Latency tables (cycles), index = code
  // ==========================================================================
  localparam logic [5:0] MRL_RL_NOINV [8] = '{6'd6, 6'd10, 6'd14, 6'd20,
                                              6'd24, 6'd28, 6'd32, 6'd36};
  localparam logic [5:0] MRL_RL_INV   [8] = '{6'd6, 6'd12, 6'd16, 6'd22,
                                              6'd28, 6'd32, 6'd36, 6'd40};
  localparam logic [5:0] MRL_WL_A     [8] = '{6'd4, 6'd6, 6'd8, 6'd10,
                                              6'd12, 6'd14, 6'd16, 6'd18};
  localparam logic [5:0] MRL_WL_B     [8] = '{6'd4, 6'd8, 6'd12, 6'd18,
                                              6'd22, 6'd26, 6'd30, 6'd34};
  localparam logic [5:0] MRL_NWR      [8] = '{6'd6, 6'd10, 6'd16, 6'd20,
                                              6'd24, 6'd30, 6'd34, 6'd40};
  localparam logic [5:0] MRL_READ_TO_PRECHARGE_CYCLES     [8] = '{6'd8, 6'd8, 6'd8, 6'd8,
                                              6'd10, 6'd12, 6'd14, 6'd16};
  localparam logic [5:0] MRL_BL32_ADD = 6'd8;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       wr;    // Mode-register write strobe
    logic       rd;    // Mode-register read strobe
    logic [5:0] addr;
    logic [7:0] op;
  } mrl_cmd_s;

  typedef struct packed {
    logic [5:0] read_latency;
    logic [5:0] write_latency;
    logic [5:0] write_recovery;
    logic [5:0] read_to_pre;
    logic       write_postamble_len;
    logic       write_inversion_enable;
    logic       read_inversion_enable;
    logic       pullup_cal_point;
    logic [2:0] pulldown_strength;
    logic       write_level;
  } mrl_cfg_s;

  typedef enum logic [1:0] {
    MRL_PRE_IDLE = 2'b00,
    MRL_PRE_WAIT = 2'b01,
    MRL_PRE_FIRE = 2'b10
  } mrl_pre_e;

endpackage : mrl_pkg

// [src/mrl_precharge_timer.sv]
// Purpose: Auto-precharge delay counter after a read or write burst
// Assumes: Start pulse carries the delay; loads only while idle
// Notes:   Fire pulse is one cycle when the count has elapsed
`timescale 1ns/1ps
module mrl_precharge_timer
  import mrl_pkg::*;
#(
  parameter int W = 7
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] delay,
  output logic              fire,
  output logic              busy
);

  mrl_pre_e     st_q;
  logic [W-1:0] cnt_q;

  // ==========================================================================
  // Count down and fire
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= MRL_PRE_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        MRL_PRE_IDLE: begin
          if (start) begin
            cnt_q <= delay;
            st_q  <= (delay <= W'(1)) ? MRL_PRE_FIRE : MRL_PRE_WAIT;
          end
        end
        MRL_PRE_WAIT: begin
          cnt_q <= cnt_q - W'(1);
          if (cnt_q <= W'(2)) begin
            st_q <= MRL_PRE_FIRE;
          end
        end
        MRL_PRE_FIRE: begin
          st_q <= MRL_PRE_IDLE;
        end
        default: st_q <= MRL_PRE_IDLE;
      endcase
    end
  end

  assign fire = (st_q == MRL_PRE_FIRE);
  assign busy = (st_q != MRL_PRE_IDLE);

endmodule : mrl_precharge_timer
